/* File: sleep_ctrl_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * end-device sleep controller.
 * Assumes a 125 MHz hclk and a 32-bit AHB-Lite register port.
 */
`ifndef SLEEP_CTRL_REGS_SVH
`define SLEEP_CTRL_REGS_SVH

// Clock and time base
`define CLK_HZ              125000000
`define MS_TIME             1
`define MS_CYCLES           (`CLK_HZ / 1000 * `MS_TIME)
`define POLL_INTERVAL_MS    7'h64
`define FIRST_POLL_STD_MS   3'h2
`define FIRST_POLL_HP_MS    3'h6
`define SLEEP_UNIT_MS       4'ha

// Register byte offsets
`define OFF_CTRL            8'h00
`define OFF_PERIOD          8'h04
`define OFF_MULT            8'h08
`define OFF_OPTS            8'h0c
`define OFF_STAY            8'h10
`define OFF_STATUS          8'h14
`define OFF_CMD             8'h18

// Field positions
`define CTRL_FC_BIT         4
`define CTRL_HP_BIT         5
`define OPT_FULL_STAY_BIT   1
`define OPT_EXTENDED_BIT    2
`define CMD_SLEEP_NOW_BIT   0

// Mode encodings
`define MODE_PIN            3'h1
`define MODE_CYC            3'h4
`define MODE_CYC_PIN        3'h5

// Ranges and reset values
`define PERIOD_MIN          12'h020
`define PERIOD_MAX          12'haf0
`define MULT_MIN            16'h0001
`define MODE_RST            3'h0
`define PERIOD_RST          12'h020
`define MULT_RST            16'h0001
`define OPTS_RST            8'h00
`define STAY_RST            16'h1388

`endif

/* File: sleep_ctrl_pkg.sv */
/*
 * Types of the end-device sleep controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sleep_ctrl_pkg;
    typedef enum logic [2:0] {S_AWAKE, S_DRAIN, S_SLEEP, S_WAKE, S_POLL} state_e;
endpackage

/* File: ms_tick_gen.sv */
/*
 * Millisecond tick divider: one-cycle enable pulse every CYCLES clocks.
 * Assumes one free-running clock.
 */
`timescale 1ns/10ps
`default_nettype none
module ms_tick_gen #(
    parameter int CYCLES = 125000
) (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Tick
    output logic      tick
);
    localparam int W = $clog2(CYCLES);
    logic [W-1:0] cnt_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end
        else
        begin
            tick <= (cnt_q == W'(CYCLES - 1));
            if (cnt_q == W'(CYCLES - 1))
                cnt_q <= '0;
            else
                cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: end_device_sleep_controller.sv */
/*
 * Sleep and wake sequencer of a radio end device: pin sleep, short and
 * extended cyclic sleep, parent polling, stay-awake timer, awake and CTS pins.
 * Assumes an AHB-Lite master with one slave, a radio stack that answers polls
 * and reports join and data activity, and all inputs synchronous to hclk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sleep_ctrl_regs.svh"

// Function
// - Mode value 1 selects pin-controlled sleep.
// - On sleep request, finish transmit or receive before sleeping.
// - While not joined, sleep waits for the join attempt to finish.
// - Host drives request low to wake; device wakes on low level.
// - First poll after pin wake within 1-2 ms, or 6 ms high-power.
// - Awake and joined, poll parent every 100 ms.
// - Modes 4 and 5 are cyclic; 5 also wakes on request falling edge.
// - Each cyclic wake polls; stay on pending or serial data, else sleep.
// - Awake indicator high when awake, low when asleep.
// - With flow control on, CTS low when awake, high when asleep.
// - In cyclic sleep, data starts and restarts the stay-awake timer.
// - Cyclic awake ends on timer expiry or sleep-immediately command.
// - Sleep period accepts 0x20 to 0xAF0, 10 ms per count.
// - Period multiplier accepts 1 to 0xFFFF.
// - Option 0x02 forces full stay time; 0x04 enables extended sleep.
// - Short cyclic sleep lasts one period, then polls the parent.
// - Poll with pending data starts stay timer, polling every 100 ms.
// - Multiplier 1 raises indicator each wake; larger only on data or count.
// - Radio data during silent wake raises the indicator at once.
// - Extended sleep lasts period count times multiplier, 10 ms units.
// - While asleep, serial and radio data are ignored.
module end_device_sleep_controller #(
    parameter int MS_CYCLES = `MS_CYCLES
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Host pins
    input  wire logic        sleep_request_in,
    output logic             awake_out,
    output logic             cts_n_out,
    // Radio stack
    input  wire logic        joined,
    input  wire logic        join_busy,
    input  wire logic        txrx_busy,
    input  wire logic        poll_ack,
    input  wire logic        poll_data_pending,
    input  wire logic        rf_data_rx,
    input  wire logic        serial_rx,
    output logic             poll_req,
    output logic             low_power
);
    sleep_ctrl_pkg::state_e state_q;
    logic [2:0]  sleep_mode_select_q;
    logic        flow_control_config_q;
    logic        high_power_q;
    logic [11:0] sleep_period_count_q;
    logic [15:0] sleep_period_multiplier_q;
    logic [7:0]  opts_q;
    logic [15:0] stay_awake_time_q;
    logic        dp_wr_q;
    logic [7:0]  dp_addr_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_mux;
    logic        ms_tick;
    logic        req_prev_q;
    logic [3:0]  unit_q;
    logic [11:0] per_left_q;
    logic [15:0] rep_left_q;
    logic [15:0] stay_left_q;
    logic        stay_run_q;
    logic [6:0]  poll_ms_q;
    logic [2:0]  dly_q;
    logic [15:0] wake_cnt_q;
    logic        silent_q;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    ms_tick_gen #(.CYCLES(MS_CYCLES)) u_ms (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (ms_tick)
    );

    // Decoded conditions
    wire addr_ok   = hsel && htrans[1] && hready && (hsize == 3'h2);
    wire pin_mode  = (sleep_mode_select_q == `MODE_PIN);
    wire cyc_mode  = (sleep_mode_select_q == `MODE_CYC) || (sleep_mode_select_q == `MODE_CYC_PIN);
    wire extended  = opts_q[`OPT_EXTENDED_BIT];
    wire full_stay = opts_q[`OPT_FULL_STAY_BIT];
    wire asleep    = (state_q == sleep_ctrl_pkg::S_SLEEP);
    wire rf_in     = rf_data_rx && !asleep;
    wire data_in   = (rf_data_rx || serial_rx) && !asleep;
    wire cmd_sleep = dp_wr_q && (dp_addr_q == `OFF_CMD) && hwdata[`CMD_SLEEP_NOW_BIT];
    wire stay_exp  = stay_run_q && (stay_left_q == 16'h0000);
    wire can_sleep = !txrx_busy && !join_busy;
    wire unit_tick = ms_tick && (unit_q == `SLEEP_UNIT_MS - 4'h1);
    wire sleep_done = unit_tick && (per_left_q == 12'h001) && (rep_left_q == 16'h0001);
    wire pin_fall  = req_prev_q && !sleep_request_in;
    wire wake_go   = pin_mode ? !sleep_request_in
                   : cyc_mode ? (sleep_done || ((sleep_mode_select_q == `MODE_CYC_PIN) && pin_fall))
                   : 1'b1;
    wire dly_done  = ms_tick && (dly_q <= 3'h1);
    wire stay_cond = poll_data_pending || full_stay || stay_run_q;
    wire poll_stay = (state_q == sleep_ctrl_pkg::S_POLL) && poll_ack && stay_cond;
    wire enter_sleep = ((state_q == sleep_ctrl_pkg::S_DRAIN) && can_sleep && sleep_mode_select_q != `MODE_RST)
                     || ((state_q == sleep_ctrl_pkg::S_POLL) && poll_ack && !stay_cond);
    wire leave_sleep = asleep && wake_go;
    wire loud_wake = extended || (sleep_period_multiplier_q == `MULT_MIN)
                   || (wake_cnt_q >= sleep_period_multiplier_q - `MULT_MIN);
    wire awake_poll = joined && ms_tick && (poll_ms_q == `POLL_INTERVAL_MS - 7'h01)
                    && ((state_q == sleep_ctrl_pkg::S_AWAKE) || (state_q == sleep_ctrl_pkg::S_DRAIN));

    // Bus address phase; read data is answered one cycle later
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            `OFF_CTRL:   rd_mux = {26'h0, high_power_q, flow_control_config_q, 1'b0, sleep_mode_select_q};
            `OFF_PERIOD: rd_mux = {20'h0_0000, sleep_period_count_q};
            `OFF_MULT:   rd_mux = {16'h0000, sleep_period_multiplier_q};
            `OFF_OPTS:   rd_mux = {24'h00_0000, opts_q};
            `OFF_STAY:   rd_mux = {16'h0000, stay_awake_time_q};
            `OFF_STATUS: rd_mux = {24'h00_0000, low_power, joined, silent_q, awake_out, stay_run_q, state_q};
            default:     rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_q   <= 1'b0;
            dp_addr_q <= 8'h00;
            rdata_q   <= 32'h0000_0000;
        end
        else
        begin
            dp_wr_q <= addr_ok && hwrite;
            if (addr_ok)
                dp_addr_q <= haddr[7:0];
            rdata_q <= (addr_ok && !hwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Configuration registers, written in the data phase; out-of-range values clamp
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sleep_mode_select_q       <= `MODE_RST;
            flow_control_config_q     <= 1'b0;
            high_power_q              <= 1'b0;
            sleep_period_count_q      <= `PERIOD_RST;
            sleep_period_multiplier_q <= `MULT_RST;
            opts_q                    <= `OPTS_RST;
            stay_awake_time_q         <= `STAY_RST;
        end
        else if (dp_wr_q)
        begin
            case (dp_addr_q)
                `OFF_CTRL:
                begin
                    sleep_mode_select_q   <= hwdata[2:0];
                    flow_control_config_q <= hwdata[`CTRL_FC_BIT];
                    high_power_q          <= hwdata[`CTRL_HP_BIT];
                end
                `OFF_PERIOD:
                begin
                    if (hwdata < {20'h0_0000, `PERIOD_MIN})
                        sleep_period_count_q <= `PERIOD_MIN;
                    else if (hwdata > {20'h0_0000, `PERIOD_MAX})
                        sleep_period_count_q <= `PERIOD_MAX;
                    else
                        sleep_period_count_q <= hwdata[11:0];
                end
                `OFF_MULT:
                    sleep_period_multiplier_q <= (hwdata[15:0] == 16'h0000) ? `MULT_MIN : hwdata[15:0];
                `OFF_OPTS:   opts_q <= hwdata[7:0];
                `OFF_STAY:   stay_awake_time_q <= hwdata[15:0];
                default:     ;
            endcase
        end
    end

    // Sequencer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_q <= sleep_ctrl_pkg::S_AWAKE;
        else
        begin
            case (state_q)
                sleep_ctrl_pkg::S_AWAKE:
                    if ((pin_mode && sleep_request_in)
                        || (cyc_mode && (cmd_sleep || stay_exp || !stay_run_q)))
                        state_q <= sleep_ctrl_pkg::S_DRAIN;
                sleep_ctrl_pkg::S_DRAIN:
                    if (sleep_mode_select_q == `MODE_RST || (pin_mode && !sleep_request_in))
                        state_q <= sleep_ctrl_pkg::S_AWAKE;
                    else if (enter_sleep)
                        state_q <= sleep_ctrl_pkg::S_SLEEP;
                sleep_ctrl_pkg::S_SLEEP:
                    if (wake_go)
                        state_q <= sleep_ctrl_pkg::S_WAKE;
                sleep_ctrl_pkg::S_WAKE:
                    if (dly_done)
                        state_q <= (cyc_mode && joined) ? sleep_ctrl_pkg::S_POLL : sleep_ctrl_pkg::S_AWAKE;
                sleep_ctrl_pkg::S_POLL:
                    if (!cyc_mode || poll_stay)
                        state_q <= sleep_ctrl_pkg::S_AWAKE;
                    else if (enter_sleep)
                        state_q <= sleep_ctrl_pkg::S_SLEEP;
                default: state_q <= sleep_ctrl_pkg::S_AWAKE;
            endcase
        end
    end

    // Sleep length: 10 ms units, one period or period times multiplier
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            unit_q     <= 4'h0;
            per_left_q <= `PERIOD_RST;
            rep_left_q <= `MULT_RST;
            req_prev_q <= 1'b0;
        end
        else
        begin
            req_prev_q <= sleep_request_in;
            if (enter_sleep)
            begin
                unit_q     <= 4'h0;
                per_left_q <= sleep_period_count_q;
                rep_left_q <= extended ? sleep_period_multiplier_q : `MULT_MIN;
            end
            else if (asleep && ms_tick)
            begin
                unit_q <= unit_tick ? 4'h0 : unit_q + 4'h1;
                if (unit_tick && per_left_q == 12'h001)
                begin
                    per_left_q <= sleep_period_count_q;
                    if (rep_left_q != 16'h0001)
                        rep_left_q <= rep_left_q - 16'h0001;
                end
                else if (unit_tick)
                    per_left_q <= per_left_q - 12'h001;
            end
        end
    end

    // Stay-awake timer in ms; data and pending polls reload it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stay_left_q <= 16'h0000;
            stay_run_q  <= 1'b0;
        end
        else if (asleep || !cyc_mode)
        begin
            stay_left_q <= 16'h0000;
            stay_run_q  <= 1'b0;
        end
        else if (data_in || poll_stay || (poll_ack && poll_data_pending))
        begin
            stay_left_q <= stay_awake_time_q;
            stay_run_q  <= 1'b1;
        end
        else if (ms_tick && stay_run_q && stay_left_q != 16'h0000)
            stay_left_q <= stay_left_q - 16'h0001;
    end

    // Poll scheduling: first poll after wake, then every interval
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            poll_ms_q <= 7'h00;
            dly_q     <= 3'h0;
            poll_req  <= 1'b0;
        end
        else
        begin
            poll_req <= awake_poll || ((state_q == sleep_ctrl_pkg::S_WAKE) && dly_done && joined);
            if (leave_sleep)
                dly_q <= high_power_q ? `FIRST_POLL_HP_MS : `FIRST_POLL_STD_MS;
            else if (ms_tick && dly_q != 3'h0)
                dly_q <= dly_q - 3'h1;
            if (state_q != sleep_ctrl_pkg::S_AWAKE && state_q != sleep_ctrl_pkg::S_DRAIN)
                poll_ms_q <= 7'h00;
            else if (ms_tick && joined)
                poll_ms_q <= awake_poll ? 7'h00 : poll_ms_q + 7'h01;
        end
    end

    // Silent wakes keep the indicator low until radio data or the wake count says otherwise
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wake_cnt_q <= 16'h0000;
            silent_q   <= 1'b0;
        end
        else if (leave_sleep && cyc_mode)
        begin
            silent_q   <= !loud_wake;
            wake_cnt_q <= loud_wake ? 16'h0000 : wake_cnt_q + 16'h0001;
        end
        else if (rf_in || !cyc_mode)
        begin
            silent_q   <= 1'b0;
            wake_cnt_q <= 16'h0000;
        end
    end

    // Host-facing pins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            awake_out <= 1'b0;
            cts_n_out <= 1'b1;
            low_power <= 1'b0;
        end
        else
        begin
            awake_out <= !asleep && !(silent_q && !rf_in);
            cts_n_out <= flow_control_config_q ? asleep : 1'b0;
            low_power <= asleep;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_pin_entry;
        $rose(asleep) && pin_mode |-> $past(sleep_request_in, 2);
    endproperty
    a_pin_entry: assert property (p_pin_entry) else $error("pin sleep entered without request");
    property p_drain;
        $rose(asleep) |-> $past(!txrx_busy) && $past(!join_busy);
    endproperty
    a_drain: assert property (p_drain) else $error("slept while busy");
    property p_pin_wake;
        asleep && pin_mode && !sleep_request_in |=> !asleep;
    endproperty
    a_pin_wake: assert property (p_pin_wake) else $error("no wake on low request");
    property p_first_poll;
        (state_q == sleep_ctrl_pkg::S_WAKE) && dly_done && joined |=> poll_req;
    endproperty
    a_first_poll: assert property (p_first_poll) else $error("first poll missing");
    property p_ind_low;
        asleep |=> !awake_out ##1 !awake_out || !asleep;
    endproperty
    a_ind_low: assert property (p_ind_low) else $error("indicator high while asleep");
    property p_cts;
        flow_control_config_q && asleep |=> cts_n_out;
    endproperty
    a_cts: assert property (p_cts) else $error("cts low while asleep");
    property p_cmd;
        (state_q == sleep_ctrl_pkg::S_AWAKE) && cyc_mode && cmd_sleep |=> state_q == sleep_ctrl_pkg::S_DRAIN;
    endproperty
    a_cmd: assert property (p_cmd) else $error("sleep command ignored");
    property p_period;
        sleep_period_count_q >= `PERIOD_MIN && sleep_period_count_q <= `PERIOD_MAX;
    endproperty
    a_period: assert property (p_period) else $error("period out of range");
    property p_mult;
        sleep_period_multiplier_q != 16'h0000;
    endproperty
    a_mult: assert property (p_mult) else $error("multiplier zero");
    property p_ignore;
        asleep && !leave_sleep |=> stay_left_q == 16'h0000 && !stay_run_q;
    endproperty
    a_ignore: assert property (p_ignore) else $error("data accepted while asleep");
    property p_rf_raise;
        silent_q && rf_in && !asleep |=> awake_out;
    endproperty
    a_rf_raise: assert property (p_rf_raise) else $error("rf data did not raise indicator");

    c_pin_sleep: cover property ($rose(asleep) && pin_mode);
    c_cyc_stay: cover property (poll_stay);
    c_silent: cover property (leave_sleep && cyc_mode && !loud_wake);
endmodule
`default_nettype wire

/* File: stack_model.sv */
/* Radio stack partner: answers each poll with an acknowledge, soon or late.
   Assumes poll_req is a one-cycle pulse synchronous to hclk. */
`timescale 1ns/10ps
`default_nettype none
module stack_model (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Bench control
    input  wire logic pend,
    input  wire logic slow,
    // Poll exchange
    input  wire logic poll_req,
    output logic      poll_ack,
    output logic      poll_data_pending
);
    logic [4:0] cnt_q;
    logic       tog_q;
    // Pending means nothing without the acknowledge, so it toggles meanwhile
    assign poll_data_pending = poll_ack ? pend : tog_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q    <= 5'h0;
            poll_ack <= 1'b0;
            tog_q    <= 1'b0;
        end
        else
        begin
            tog_q    <= ~tog_q;
            poll_ack <= (cnt_q == 5'h1);
            if (poll_req)
                cnt_q <= slow ? 5'h14 : 5'h2;
            else if (cnt_q != 5'h0)
                cnt_q <= cnt_q - 5'h1;
        end
    end
endmodule
`default_nettype wire

/* File: testbench.sv */
/* Self-checking bench of the sleep controller: registers, pin and cyclic sleep.
   Assumes MS_CYCLES of 10, so one millisecond lasts ten clocks. */
`timescale 1ns/10ps
`default_nettype none
`include "sleep_ctrl_regs.svh"
module testbench;
    logic             hclk, hresetn, hsel, hwrite, sleep_request_in, joined, join_busy, txrx_busy;
    logic             rf_data_rx, serial_rx, pend, slow;
    logic [31:0]      haddr, hwdata, rd, v;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    wire logic        hreadyout, hresp, awake_out, cts_n_out, poll_req, low_power, poll_ack, poll_data_pending;
    wire logic [31:0] hrdata;
    int               miscompares, total_checks, cyc, n;
    end_device_sleep_controller #(.MS_CYCLES(10)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .sleep_request_in(sleep_request_in), .awake_out(awake_out), .cts_n_out(cts_n_out),
        .joined(joined), .join_busy(join_busy), .txrx_busy(txrx_busy), .poll_ack(poll_ack),
        .poll_data_pending(poll_data_pending), .rf_data_rx(rf_data_rx), .serial_rx(serial_rx),
        .poll_req(poll_req), .low_power(low_power));
    stack_model partner (.hclk(hclk), .hresetn(hresetn), .pend(pend), .slow(slow), .poll_req(poll_req),
        .poll_ack(poll_ack), .poll_data_pending(poll_data_pending));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask
    // Waits for low_power (p=0) or poll_req (p=1) to equal v; n counts clocks
    task automatic wt(input bit p, input logic v, input int lim);
        n = 0;
        while (((p ? poll_req : low_power) !== v) && n < lim)
        begin
            @(posedge hclk);
            n++;
        end
    endtask
    task automatic pulse(input bit s);
        @(posedge hclk);
        if (s)
            serial_rx <= 1'b1;
        else
            rf_data_rx <= 1'b1;
        @(posedge hclk);
        serial_rx  <= 1'b0;
        rf_data_rx <= 1'b0;
    endtask
    function automatic logic [31:0] clamp(input logic [31:0] x);
        return (x < 32'h20) ? 32'h20 : (x > 32'haf0) ? 32'haf0 : x;
    endfunction
    function automatic logic [31:0] in_rng(input int x, input int lo, input int hi);
        return {31'h0, x >= lo && x <= hi};
    endfunction
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            miscompares++;
            finish_test;
        end
    end
    initial
    begin
        {hresetn, hsel, hwrite, sleep_request_in, joined, join_busy, txrx_busy} = 7'h0;
        {rf_data_rx, serial_rx, pend, slow, htrans} = 6'h0;
        haddr  = 32'h0;
        hwdata = 32'h0;
        hsize  = 3'h2;
        void'($urandom(76068));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("awake", {31'h0, awake_out}, 32'h1);
        rdchk("period", `OFF_PERIOD, 32'h20);
        rdchk("mult", `OFF_MULT, 32'h1);
        rdchk("stay", `OFF_STAY, 32'h1388);
        rdchk("unmapped", 8'h1c, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            v = (i == 0) ? 32'h1f : (i == 1) ? 32'haf1 : $urandom_range(32'hb00, 32'h10);
            bus(1'b1, `OFF_PERIOD, v);
            rdchk("period", `OFF_PERIOD, clamp(v));
        end
        bus(1'b1, `OFF_MULT, 32'h0);
        rdchk("mult", `OFF_MULT, 32'h1);
        $display("register test done");
        bus(1'b1, `OFF_CTRL, 32'h11);
        join_busy        <= 1'b1;
        txrx_busy        <= 1'b1;
        sleep_request_in <= 1'b1;
        repeat (50) @(posedge hclk);
        chk("lp", {31'h0, low_power}, 32'h0);
        join_busy <= 1'b0;
        joined    <= 1'b1;
        repeat (50) @(posedge hclk);
        chk("lp", {31'h0, low_power}, 32'h0);
        txrx_busy <= 1'b0;
        wt(0, 1'b1, 20);
        chk("lp", {31'h0, low_power}, 32'h1);
        chk("awake", {31'h0, awake_out}, 32'h0);
        chk("cts_n", {31'h0, cts_n_out}, 32'h1);
        pulse(0);
        pulse(1);
        repeat (20) @(posedge hclk);
        chk("lp", {31'h0, low_power}, 32'h1);
        sleep_request_in <= 1'b0;
        wt(0, 1'b0, 10);
        repeat (2) @(posedge hclk);
        chk("awake", {31'h0, awake_out}, 32'h1);
        chk("cts_n", {31'h0, cts_n_out}, 32'h0);
        wt(1, 1'b1, 40);
        chk("first poll", in_rng(n, 5, 25), 32'h1);
        @(posedge hclk);
        wt(1, 1'b1, 1100);
        chk("poll gap", in_rng(n, 985, 1010), 32'h1);
        bus(1'b1, `OFF_CTRL, 32'h31);
        sleep_request_in <= 1'b1;
        wt(0, 1'b1, 50);
        sleep_request_in <= 1'b0;
        wt(0, 1'b0, 10);
        wt(1, 1'b1, 100);
        chk("hp poll", in_rng(n, 40, 70), 32'h1);
        $display("pin sleep test done");
        bus(1'b1, `OFF_PERIOD, 32'h20);
        bus(1'b1, `OFF_STAY, 32'h96);
        bus(1'b1, `OFF_CTRL, 32'h14);
        wt(0, 1'b1, 100);
        chk("lp", {31'h0, low_power}, 32'h1);
        wt(0, 1'b0, 4000);
        chk("short sleep", in_rng(n, 3150, 3230), 32'h1);
        repeat (2) @(posedge hclk);
        chk("awake", {31'h0, awake_out}, 32'h1);
        wt(0, 1'b1, 100);
        chk("lp", {31'h0, low_power}, 32'h1);
        bus(1'b1, `OFF_OPTS, 32'h4);
        bus(1'b1, `OFF_MULT, 32'h2);
        wt(0, 1'b0, 4000);
        wt(0, 1'b1, 100);
        pend <= 1'b1;
        slow <= 1'($urandom);
        wt(0, 1'b0, 7000);
        chk("ext sleep", in_rng(n, 6350, 6430), 32'h1);
        wt(1, 1'b1, 100);
        repeat (30) @(posedge hclk);
        pend <= 1'b0;
        repeat (1000) @(posedge hclk);
        chk("lp", {31'h0, low_power}, 32'h0);
        pulse(0);
        wt(0, 1'b1, 3000);
        chk("stay", in_rng(n, 1400, 1600), 32'h1);
        pend <= 1'b1;
        wt(0, 1'b0, 7000);
        wt(1, 1'b1, 100);
        repeat (30) @(posedge hclk);
        pend <= 1'b0;
        bus(1'b1, `OFF_CMD, 32'h1);
        wt(0, 1'b1, 20);
        chk("lp", {31'h0, low_power}, 32'h1);
        bus(1'b1, `OFF_OPTS, 32'h2);
        bus(1'b1, `OFF_CTRL, 32'h15);
        sleep_request_in <= 1'b1;
        repeat (20) @(posedge hclk);
        sleep_request_in <= 1'b0;
        wt(0, 1'b0, 20);
        chk("lp", {31'h0, low_power}, 32'h0);
        chk("awake", {31'h0, awake_out}, 32'h0);
        wt(0, 1'b1, 2000);
        chk("full stay", in_rng(n, 1450, 1650), 32'h1);
        bus(1'b1, `OFF_CTRL, 32'h4);
        bus(1'b1, `OFF_MULT, 32'h3);
        sleep_request_in <= 1'b1;
        repeat (20) @(posedge hclk);
        sleep_request_in <= 1'b0;
        repeat (20) @(posedge hclk);
        chk("lp", {31'h0, low_power}, 32'h1);
        chk("cts_n", {31'h0, cts_n_out}, 32'h0);
        wt(0, 1'b0, 4000);
        chk("awake", {31'h0, awake_out}, 32'h0);
        pulse(0);
        repeat (2) @(posedge hclk);
        chk("awake", {31'h0, awake_out}, 32'h1);
        $display("cyclic sleep test done");
        finish_test;
    end
endmodule
`default_nettype wire
